// ==== src/ucs_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
module ucs_channel
   import ucs_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire ucs_bus_type bus_in,
   output logic [7:0]       rdata_out,
   output logic             irq_out,
   input  wire logic        sclk_in,
   output logic             sclk_out,
   output logic             sclk_oe_n_out,
   input  wire logic        rxd_in,
   output logic             txd_out,
   output logic             txd_oe_n_out,
   input  wire logic        cts_n_in,
   output logic             rts_n_out,
   output logic             rts_oe_n_out,
   input  wire logic        shutdown_n_in
);
   logic [7:0]    control_r;
   logic [2:0]    mode_r;
   logic [7:0]    div_r;
   logic          cutoff_en_r;
   logic [7:0]    txbuf_r;
   logic [7:0]    rxbuf_r;
   logic          tbe_r;
   logic          rbf_r;
   logic          oer_r;
   logic [2:0]    irq_stat_r;
   logic [2:0]    irq_mask_r;
   logic [7:0]    tsr_r;
   logic [7:0]    rsr_r;
   logic [3:0]    bit_cnt_r;
   logic [7:0]    div_cnt_r;
   logic          int_clk_r;
   logic          clk_prev_r;
   logic          word_done_r;
   ucs_state_type state_r;
   ucs_state_type state_nxt;
   logic          sclk_s;
   logic          rxd_s;
   logic          cts_n_s;
   logic          shut_n_s;
   logic          ext_clk;
   logic          shift_clk;
   logic          lead_edge;
   logic          trail_edge;
   logic          cutoff;
   logic          enabled;
   logic          start_ok;
   logic          wr_tx;
   logic          rd_rx;
   logic          rd_irq;

   function automatic logic hit(input ucs_bus_type b, input logic [3:0] a);
      return b.addr == a;
   endfunction

   ucs_sync u_sync_sclk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(sclk_in), .q_out(sclk_s));
   ucs_sync u_sync_rxd (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(rxd_in), .q_out(rxd_s));
   ucs_sync u_sync_cts (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(cts_n_in), .q_out(cts_n_s));
   ucs_sync u_sync_sd (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(shutdown_n_in), .q_out(shut_n_s));

   assign enabled  = (mode_r != MODE_OFF);
   assign cutoff   = cutoff_en_r && !shut_n_s;
   assign wr_tx    = bus_in.wr && hit(bus_in, ADDR_TXBUF);
   assign rd_rx    = bus_in.rd && hit(bus_in, ADDR_RXBUF);
   assign rd_irq   = bus_in.rd && hit(bus_in, ADDR_IRQ_STAT);
   assign ext_clk  = !control_r[CTL_INTCK];
   // the shift clock exists only while the transmitter is armed with data
   assign start_ok = enabled && control_r[CTL_TE] && !tbe_r
                     && !(control_r[CTL_CTSEN] && cts_n_s);
   assign shift_clk = ext_clk ? sclk_s : int_clk_r;
   // polarity 0: leading edge falling (drive), trailing rising (sample)
   assign lead_edge  = (clk_prev_r != shift_clk) && (shift_clk == control_r[CTL_CLOCK_POLARITY_SELECT]);
   assign trail_edge = (clk_prev_r != shift_clk) && (shift_clk != control_r[CTL_CLOCK_POLARITY_SELECT]);

   // register writes
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         control_r   <= CONTROL_RST;
         mode_r      <= MODE_RST;
         irq_mask_r  <= IRQ_RST;
         cutoff_en_r <= 1'b0;
      end else if (bus_in.wr) begin
         if (hit(bus_in, ADDR_CONTROL)) begin
            control_r <= bus_in.addr_wdata;
         end
         if (hit(bus_in, ADDR_MODE)) begin
            mode_r <= bus_in.addr_wdata[2:0];
         end
         if (hit(bus_in, ADDR_IRQ_MASK)) begin
            irq_mask_r <= bus_in.addr_wdata[2:0];
         end
         if (hit(bus_in, ADDR_CUTOFF)) begin
            cutoff_en_r <= bus_in.addr_wdata[0];
         end
      end
   end

   // internal clock divider, runs only while shifting from the transmitter
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_r     <= DIV_RST;
         div_cnt_r <= 8'h00;
         int_clk_r <= 1'b1;
      end else begin
         if (bus_in.wr && hit(bus_in, ADDR_CUTOFF)) begin
            div_r <= {1'b0, bus_in.addr_wdata[7:1]} | 8'h01;
         end
         if (state_r == ST_SHIFT && control_r[CTL_INTCK]) begin
            if (div_cnt_r >= div_r) begin
               div_cnt_r <= 8'h00;
               int_clk_r <= ~int_clk_r;
            end else begin
               div_cnt_r <= div_cnt_r + 8'h01;
            end
         end else begin
            div_cnt_r <= 8'h00;
            int_clk_r <= !control_r[CTL_CLOCK_POLARITY_SELECT];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_prev_r <= 1'b1;
      end else begin
         clk_prev_r <= shift_clk;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_ok) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (trail_edge && bit_cnt_r == BITS_WORD - 4'h1) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
      if (!enabled) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // shifter: transmit data (dummy when only receiving) and receive data
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tsr_r       <= 8'h00;
         rsr_r       <= 8'h00;
         bit_cnt_r   <= 4'h0;
         txd_out     <= 1'b1;
         tbe_r       <= 1'b1;
         txbuf_r     <= 8'h00;
         word_done_r <= 1'b0;
      end else begin
         word_done_r <= 1'b0;
         if (state_r == ST_IDLE && start_ok) begin
            tsr_r     <= txbuf_r;
            tbe_r     <= 1'b1;
            bit_cnt_r <= 4'h0;
         end
         // a write in the load cycle refills the buffer instead of being lost
         if (wr_tx) begin
            txbuf_r <= bus_in.addr_wdata;
            tbe_r   <= 1'b0;
         end
         if (state_r == ST_SHIFT) begin
            if (lead_edge) begin
               txd_out <= tsr_r[0];
               tsr_r   <= {1'b1, tsr_r[7:1]};
            end
            if (trail_edge) begin
               rsr_r     <= {rxd_s, rsr_r[7:1]};
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (bit_cnt_r == BITS_WORD - 4'h1) begin
                  word_done_r <= control_r[CTL_RE];
               end
            end
         end else if (!enabled) begin
            // a disabled channel parks the line high, not at its last data bit
            txd_out <= 1'b1;
         end
      end
   end

   // receive buffer, full and overrun flags
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rxbuf_r <= 8'h00;
         rbf_r   <= 1'b0;
         oer_r   <= 1'b0;
      end else begin
         if (word_done_r) begin
            rxbuf_r <= rsr_r;
            rbf_r   <= 1'b1;
            oer_r   <= rbf_r;
         end else if (rd_rx) begin
            rbf_r <= 1'b0;
            oer_r <= 1'b0;
         end
      end
   end

   // request-to-send: low when ready, high once a word starts
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rts_n_out <= 1'b1;
      end else if (control_r[CTL_INTCK] || !control_r[CTL_RTSEN]) begin
         rts_n_out <= 1'b1;
      end else if (state_r != ST_IDLE) begin
         rts_n_out <= 1'b1;
      end else begin
         rts_n_out <= !(enabled && control_r[CTL_RE] && !rbf_r);
      end
   end

   // sticky events; set beats the read that clears
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_r <= IRQ_RST;
      end else begin
         irq_stat_r <= (rd_irq ? 3'h0 : irq_stat_r)
                       | {word_done_r && rbf_r,
                          state_r == ST_IDLE && start_ok,
                          word_done_r && !oer_r};
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_r & irq_mask_r);
      end
   end

   // pin drivers; the clock pin drives whenever the channel is enabled on the internal clock and not cut off, idle or shifting; open-drain releases it while high
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_out      <= 1'b1;
         sclk_oe_n_out <= 1'b1;
         txd_oe_n_out  <= 1'b1;
         rts_oe_n_out  <= 1'b1;
      end else begin
         sclk_out      <= control_r[CTL_CLOCK_OPEN_DRAIN_SELECT] ? 1'b0 : int_clk_r;
         // open-drain: only pull low, release for high
         sclk_oe_n_out <= cutoff || !enabled || ext_clk
                          || (control_r[CTL_CLOCK_OPEN_DRAIN_SELECT] && int_clk_r);
         txd_oe_n_out  <= cutoff || !enabled;
         rts_oe_n_out  <= cutoff || !enabled || !control_r[CTL_RTSEN];
      end
   end

   // read data one cycle after the read strobe, zero otherwise
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (bus_in.rd) begin
         case (bus_in.addr)
            ADDR_CONTROL:  rdata_out <= control_r;
            ADDR_MODE:     rdata_out <= {5'h00, mode_r};
            ADDR_TXBUF:    rdata_out <= txbuf_r;
            ADDR_RXBUF:    rdata_out <= rxbuf_r;
            ADDR_STATUS:   rdata_out <= {4'h0, state_r != ST_IDLE, oer_r, rbf_r, tbe_r};
            ADDR_IRQ_STAT: rdata_out <= {5'h00, irq_stat_r};
            ADDR_IRQ_MASK: rdata_out <= {5'h00, irq_mask_r};
            ADDR_CUTOFF:   rdata_out <= {div_r[6:0], cutoff_en_r};
            default:       rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end
endmodule // ucs_channel
`default_nettype wire

// ==== src/ucs_pkg.sv ====
// Behaviour
// - with external clock and handshake on, request-to-send goes low when ready to receive
// - request-to-send goes high as soon as a receive operation begins
// - request-to-send handshake inactive whenever internal shift clock is selected
// - polarity 0: send on falling, sample on rising; polarity 1 reverses both
// - shift clock comes only from active transmitter; dummy data goes out while receiving
// - internal clock starts once transmit enabled and dummy data written
// - word completing while buffer full sets overrun flag, buffer contents undefined
// - further overrun after an earlier one leaves receive interrupt request unchanged
// - cutoff enable 1 and shutdown input low force shared pins to high impedance
package ucs_pkg;
   localparam logic [3:0] ADDR_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_MODE     = 4'h1;
   localparam logic [3:0] ADDR_TXBUF    = 4'h2;
   localparam logic [3:0] ADDR_RXBUF    = 4'h3;
   localparam logic [3:0] ADDR_STATUS   = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_CUTOFF   = 4'h7;

   // control register bit positions
   localparam int CTL_TE    = 0;
   localparam int CTL_RE    = 1;
   localparam int CTL_CLOCK_POLARITY_SELECT = 2;
   localparam int CTL_INTCK = 3;
   localparam int CTL_RTSEN = 4;
   localparam int CTL_CTSEN = 5;
   localparam int CTL_CLOCK_OPEN_DRAIN_SELECT  = 6;
   // status register bit positions
   localparam int ST_TBE  = 0;
   localparam int ST_RBF  = 1;
   localparam int ST_OER  = 2;
   localparam int ST_BUSY = 3;
   // interrupt bits
   localparam int IRQ_RX  = 0;
   localparam int IRQ_TX  = 1;
   localparam int IRQ_OER = 2;

   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [2:0]  MODE_RST    = 3'h0;
   localparam logic [2:0]  MODE_OFF    = 3'h0;
   localparam logic [7:0]  DIV_RST     = 8'h03;
   localparam logic [2:0]  IRQ_RST     = 3'h0;
   localparam logic [3:0]  BITS_WORD   = 4'h8;

   typedef struct packed {
      logic [7:0] addr_wdata;
      logic [3:0] addr;
      logic       wr;
      logic       rd;
   } ucs_bus_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } ucs_state_type;
endpackage

// ==== src/ucs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module ucs_sync (
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_r;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= 1'b0;
         q_out  <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule // ucs_sync
`default_nettype wire

// ==== dv/ucs_channel_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module ucs_channel_properties
   import ucs_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire ucs_bus_type bus_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        irq_out,
   input wire logic        sclk_in,
   input wire logic        sclk_out,
   input wire logic        sclk_oe_n_out,
   input wire logic        rxd_in,
   input wire logic        txd_out,
   input wire logic        txd_oe_n_out,
   input wire logic        cts_n_in,
   input wire logic        rts_n_out,
   input wire logic        rts_oe_n_out,
   input wire logic        shutdown_n_in
);
   logic [7:0] ctl_r;
   logic [2:0] mode_r;
   logic [2:0] mask_r;
   logic       cut_r;
   logic       tx_load;
   // shadow of the software settings, since the pin rules hang on them
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl_r <= CONTROL_RST;
         mode_r <= MODE_RST;
         mask_r <= IRQ_RST;
         cut_r <= 1'b0;
      end else if (bus_in.wr) begin
         case (bus_in.addr)
            ADDR_CONTROL: ctl_r <= bus_in.addr_wdata;
            ADDR_MODE: mode_r <= bus_in.addr_wdata[2:0];
            ADDR_IRQ_MASK: mask_r <= bus_in.addr_wdata[2:0];
            ADDR_CUTOFF: cut_r <= bus_in.addr_wdata[0];
            default: ;
         endcase
      end
   end
   assign tx_load = bus_in.wr && bus_in.addr == ADDR_TXBUF && mode_r != MODE_OFF && ctl_r[CTL_TE]
                    && ctl_r[CTL_RTSEN] && !ctl_r[CTL_INTCK] && !ctl_r[CTL_CTSEN];
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_rts_internal_off: assert property (ctl_r[CTL_INTCK] && $past(ctl_r[CTL_INTCK]) |-> rts_n_out)
      else $error("request-to-send active with internal clock");
   a_rts_unused_high: assert property (!ctl_r[CTL_RTSEN] && !$past(ctl_r[CTL_RTSEN]) |-> rts_n_out)
      else $error("request-to-send active while unused");
   a_rts_word_start: assert property (tx_load |-> ##[1:4] rts_n_out)
      else $error("request-to-send not raised at word start");
   a_cutoff_pins_released: assert property ((cut_r && !shutdown_n_in) [*5] |->
      sclk_oe_n_out && txd_oe_n_out && rts_oe_n_out) else $error("pins driven during cutoff");
   a_read_idle_zero: assert property (!$past(bus_in.rd) || $past(bus_in.addr) > ADDR_CUTOFF |-> rdata_out == 8'h00)
      else $error("read data outside answer cycle");
   a_irq_masked_low: assert property ((mask_r == 3'h0) [*2] |-> !irq_out)
      else $error("interrupt with all sources masked");
   a_ext_clock_input: assert property (!ctl_r[CTL_INTCK] && !$past(ctl_r[CTL_INTCK]) |-> sclk_oe_n_out)
      else $error("clock pin driven with external clock");
   a_txd_off_idle: assert property ((mode_r == MODE_OFF) [*3] |-> txd_out)
      else $error("transmit line not idle while channel off");
endmodule // ucs_channel_properties
`default_nettype wire

// ==== dv/ucs_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
module ucs_peer (
   input  wire logic       go_in,
   input  wire logic       pol_in,
   input  wire logic [7:0] data_in,
   input  wire logic       txd_in,
   output logic            sclk_out,
   output logic            rxd_out,
   output logic [7:0]      got_out
);
   logic lead_r = 1'b0;
   initial rxd_out = 1'b1;
   initial got_out = 8'h00;
   // clock rests at the idle level of the polarity outside frames
   assign sclk_out = ~(pol_in ^ lead_r);
   // device bit is read late in the cell, well after its synchroniser delay
   always @(posedge go_in) begin
      for (int i = 0; i < 8; i++) begin
         lead_r = 1'b1;
         #10 rxd_out = data_in[i];
         #150 lead_r = 1'b0;
         #60 got_out[i] = txd_in;
         #100;
      end
      rxd_out = ~rxd_out;
   end
endmodule // ucs_peer
`default_nettype wire

// ==== dv/ucs_channel_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define UCS_CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin errors++; $display("BAD %s expected %0h seen %0h", nm, e, a); end end
module ucs_channel_tb
   import ucs_pkg::*;
;
   int          errors = 0;
   int          check_count = 0;
   logic        mclk_in = 1'b0;
   logic        rst_n_in, shutdown_n, cts_n, pol, go, loop_en, irq, txd, txd_oe_n, rts_n, rts_oe_n;
   logic        sclk_pin, sclk_drv, sclk_oe_n, peer_sclk, rxd_pin, peer_rxd;
   logic [7:0]  rdata, peer_data, peer_got;
   ucs_bus_type bus;
   assign sclk_pin = sclk_oe_n ? peer_sclk : sclk_drv;
   assign rxd_pin = loop_en ? txd : peer_rxd;
   always #20 mclk_in = ~mclk_in;
   ucs_channel dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata), .irq_out(irq),
      .sclk_in(sclk_pin), .sclk_out(sclk_drv), .sclk_oe_n_out(sclk_oe_n), .rxd_in(rxd_pin), .txd_out(txd),
      .txd_oe_n_out(txd_oe_n), .cts_n_in(cts_n), .rts_n_out(rts_n), .rts_oe_n_out(rts_oe_n),
      .shutdown_n_in(shutdown_n));
   ucs_peer peer_u (.go_in(go), .pol_in(pol), .data_in(peer_data), .txd_in(txd), .sclk_out(peer_sclk),
      .rxd_out(peer_rxd), .got_out(peer_got));
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.addr_wdata <= d;
      @(posedge mclk_in);
      bus.wr <= 1'b0;
   endtask
   task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk_in);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge mclk_in);
      bus.rd <= 1'b0;
      @(negedge mclk_in);
      `UCS_CHK(nm, e, rdata & m)
   endtask
   // the peer frame is a fixed 64 cycles, so a fixed wait covers it and the word completion
   task automatic frame(input logic [7:0] b);
      @(posedge mclk_in);
      peer_data <= b;
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      repeat (72) @(negedge mclk_in);
   endtask
   task automatic setup(input logic [7:0] ctl);
      wr(ADDR_CONTROL, ctl);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h05);
   endtask
   task automatic s_reset();
      chk_rd("control", ADDR_CONTROL, 8'hFF, CONTROL_RST);
      chk_rd("mask", ADDR_IRQ_MASK, 8'hFF, {5'h00, IRQ_RST});
      wr(4'hC, 8'hFF);
      chk_rd("unmapped", 4'hC, 8'hFF, 8'h00);
   endtask
   task automatic s_ext(input logic p);
      @(posedge mclk_in);
      pol <= p;
      cts_n <= p;
      // the second polarity also runs the clear-to-send gate
      setup(8'h13 | {2'b00, p, 2'b00, p, 2'b00});
      repeat (4) @(negedge mclk_in);
      `UCS_CHK("rts ready", 1'b0, rts_n)
      wr(ADDR_TXBUF, 8'hA5);
      if (p) begin
         repeat (4) @(negedge mclk_in);
         `UCS_CHK("cts hold", 1'b0, rts_n)
         @(posedge mclk_in);
         cts_n <= 1'b0;
      end
      repeat (6) @(negedge mclk_in);
      `UCS_CHK("rts busy", 1'b1, rts_n)
      frame(8'h3C);
      `UCS_CHK("irq raised", 1'b1, irq)
      `UCS_CHK("tx word", 8'hA5, peer_got)
      chk_rd("irq status", ADDR_IRQ_STAT, 8'h05, 8'h01);
      chk_rd("rx word", ADDR_RXBUF, 8'hFF, 8'h3C);
      chk_rd("status", ADDR_STATUS, 8'h06, 8'h00);
      `UCS_CHK("irq cleared", 1'b0, irq)
      wr(ADDR_MODE, 8'h00);
   endtask
   task automatic s_overrun();
      @(posedge mclk_in);
      pol <= 1'b0;
      setup(8'h03);
      wr(ADDR_TXBUF, 8'h00);
      frame(8'h11);
      chk_rd("status full", ADDR_STATUS, 8'h06, 8'h02);
      chk_rd("irq first", ADDR_IRQ_STAT, 8'h05, 8'h01);
      wr(ADDR_TXBUF, 8'h00);
      frame(8'h22);
      chk_rd("overrun", ADDR_STATUS, 8'h06, 8'h06);
      chk_rd("irq second", ADDR_IRQ_STAT, 8'h04, 8'h04);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_TXBUF, 8'h00);
      frame(8'h33);
      `UCS_CHK("irq masked", 1'b0, irq)
      chk_rd("irq third", ADDR_IRQ_STAT, 8'h05, 8'h04);
      chk_rd("rx drain", ADDR_RXBUF, 8'h00, 8'h00);
      chk_rd("cleared", ADDR_STATUS, 8'h06, 8'h00);
      wr(ADDR_MODE, 8'h00);
   endtask
   task automatic s_internal();
      int   n;
      int   falls;
      logic last;
      n = 0;
      falls = 0;
      loop_en <= 1'b1;
      setup(8'h1B);
      wr(ADDR_TXBUF, 8'h5A);
      last = sclk_pin;
      while (irq !== 1'b1 && n < 300) begin
         @(negedge mclk_in);
         falls += int'(last && !sclk_pin);
         last = sclk_pin;
         n++;
      end
      `UCS_CHK("irq wait", 1'b1, irq)
      `UCS_CHK("clock edges", 8, falls)
      `UCS_CHK("rts internal", 1'b1, rts_n)
      chk_rd("loopback", ADDR_RXBUF, 8'hFF, 8'h5A);
      loop_en <= 1'b0;
      // pending events stay set, so an empty mask must hold the line low
      wr(ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(negedge mclk_in);
      `UCS_CHK("irq mask off", 1'b0, irq)
   endtask
   task automatic s_cutoff();
      wr(ADDR_CUTOFF, 8'h07);
      @(posedge mclk_in);
      shutdown_n <= 1'b0;
      repeat (6) @(negedge mclk_in);
      `UCS_CHK("cutoff", 3'b111, {sclk_oe_n, txd_oe_n, rts_oe_n})
      @(posedge mclk_in);
      shutdown_n <= 1'b1;
      repeat (6) @(negedge mclk_in);
      `UCS_CHK("cutoff off", 1'b0, sclk_oe_n)
      wr(ADDR_CUTOFF, 8'h06);
   endtask
   task automatic s_open_drain();
      wr(ADDR_CONTROL, 8'h48);
      repeat (3) @(negedge mclk_in);
      `UCS_CHK("open drain idle", 2'b01, {sclk_drv, sclk_oe_n})
      wr(ADDR_CONTROL, 8'h08);
      wr(ADDR_MODE, 8'h00);
      repeat (3) @(negedge mclk_in);
      `UCS_CHK("port idle", 1'b1, txd)
   endtask
   initial begin
      rst_n_in = 1'b0;
      shutdown_n = 1'b1;
      cts_n = 1'b0;
      pol = 1'b0;
      go = 1'b0;
      loop_en = 1'b0;
      peer_data = 8'h00;
      bus = '0;
      repeat (10) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      s_reset();
      s_ext(1'b0);
      s_ext(1'b1);
      s_overrun();
      s_internal();
      s_cutoff();
      s_open_drain();
      complete_run();
   end
endmodule // ucs_channel_tb
bind ucs_channel ucs_channel_properties props_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
   .rdata_out(rdata_out), .irq_out(irq_out), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n_out(sclk_oe_n_out),
   .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe_n_out(txd_oe_n_out), .cts_n_in(cts_n_in), .rts_n_out(rts_n_out),
   .rts_oe_n_out(rts_oe_n_out), .shutdown_n_in(shutdown_n_in));
`default_nettype wire
